// [logic/rof_pkg.sv]
// constants for the relay output function selector
package rof_pkg;
   // register byte offsets
   localparam logic [7:0] ROF_OFS_FUNC_SEL = 8'h00;
   localparam logic [7:0] ROF_OFS_SCALING = 8'h04;
   localparam logic [7:0] ROF_OFS_FORCE = 8'h08;
   localparam logic [7:0] ROF_OFS_MOTOR_CURRENT = 8'h0c;
   localparam logic [7:0] ROF_OFS_MOTOR_FREQ = 8'h10;
   localparam logic [7:0] ROF_OFS_TORQUE_NOM = 8'h14;
   localparam logic [7:0] ROF_OFS_TORQUE_LIMIT = 8'h18;
   localparam logic [7:0] ROF_OFS_STATUS = 8'h1c;
   // values after reset
   localparam logic [5:0] ROF_RST_FUNC_SEL = 6'h01;
   localparam logic [15:0] ROF_RST_SCALING = 16'h0064;
   localparam logic [15:0] ROF_RST_MOTOR_CURRENT = 16'h03e8;
   localparam logic [15:0] ROF_RST_MOTOR_FREQ = 16'h01f4;
   localparam logic [15:0] ROF_RST_TORQUE_NOM = 16'h03e8;
   localparam logic [15:0] ROF_RST_TORQUE_LIMIT = 16'h03e8;
   // selector codes
   localparam logic [5:0] ROF_FN_NONE = 6'h00;
   localparam logic [5:0] ROF_FN_BRAKE = 6'h01;
   localparam logic [5:0] ROF_FN_RUNNING = 6'h02;
   localparam logic [5:0] ROF_FN_CURRENT = 6'h03;
   localparam logic [5:0] ROF_FN_TORQUE = 6'h04;
   localparam logic [5:0] ROF_FN_FREQ = 6'h05;
   localparam logic [5:0] ROF_FN_TLIM_WARN = 6'h0b;
   localparam logic [5:0] ROF_FN_FORCE = 6'h0c;
   localparam logic [5:0] ROF_FN_TLIM_GEN = 6'h0d;
   localparam logic [5:0] ROF_FN_BUS_BIT0 = 6'h1e;
   localparam logic [5:0] ROF_FN_BUS_BIT7 = 6'h25;
   localparam logic [5:0] ROF_FN_BUS_OUT = 6'h26;
   // scaling and hysteresis in percent
   localparam logic [8:0] ROF_SCALE_MIN_PCT = 9'h014;
   localparam logic [8:0] ROF_SCALE_MAX_PCT = 9'h190;
   localparam logic [24:0] ROF_PCT_FULL = 25'h0000064;
   localparam logic [21:0] ROF_HYST_PCT = 22'h00000a;
   localparam logic [21:0] ROF_HYST_FULL = 22'h000064;
endpackage

// [logic/rof_limit_cmp.sv]
// limit comparator with fixed 10 percent switching hysteresis
module rof_limit_cmp
   import rof_pkg::*;
#(
   parameter int VW = 18
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // compare
   input wire logic [VW-1:0] value,
   input wire logic [VW-1:0] limit,
   output logic active
);

   typedef struct packed
   {
      logic act;
   } rof_cmp_t;

   rof_cmp_t st_r;
   rof_cmp_t st_nxt;
   logic [VW-1:0] lower;
   logic [VW+3:0] hyst_w;

   assign hyst_w = ((VW+4)'(limit) * (VW+4)'(ROF_HYST_PCT)) / (VW+4)'(ROF_HYST_FULL);
   assign lower = limit - hyst_w[VW-1:0];

   always_comb
   begin
      st_nxt = st_r;
      // set at limit, clear below lower
      if (value >= limit)
      begin
         st_nxt.act = 1'b1;
      end
      else if (value < lower)
      begin
         st_nxt.act = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign active = st_r.act;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_cmp_set;
      value >= limit |=> active;
   endproperty
   a_cmp_set: assert property (p_cmp_set) else $error("comparator missed the limit");

   property p_cmp_hold;
      active && value < limit && value >= lower |=> active;
   endproperty
   a_cmp_hold: assert property (p_cmp_hold) else $error("comparator dropped inside hysteresis band");

   property p_cmp_clear;
      value < lower && value < limit |=> !active;
   endproperty
   a_cmp_clear: assert property (p_cmp_clear) else $error("comparator stayed on below lower point");
endmodule

// [logic/rof_relay_select.sv]
// relay output function selector with apb register file
module rof_relay_select
   import rof_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // drive state from the control core
   input wire logic brake_release,
   input wire logic inverter_running,
   input wire logic generator_range,
   input wire logic vector_current_control,
   input wire logic [15:0] output_current,
   input wire logic [15:0] torque_current,
   input wire logic [15:0] output_frequency,
   input wire logic [7:0] bus_in_bits,
   input wire logic bus_out_bit,
   // relay
   output logic relay_contact
);

   typedef struct packed
   {
      logic [5:0] relay_one_function_select;
      logic [15:0] relay_one_limit_scaling;
      logic relay_force_setting;
      logic [15:0] motor_rated_current;
      logic [15:0] motor_nominal_frequency;
      logic [15:0] torque_nominal_current;
      logic [15:0] torque_current_limit_setting;
      logic contact;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
   } rof_regs_t;

   rof_regs_t st_r;
   rof_regs_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // scaling and limits

   logic scale_neg;
   logic [15:0] scale_abs;
   logic [8:0] scale_pct;
   logic [17:0] lim_current;
   logic [17:0] lim_torque;
   logic [17:0] lim_freq;
   logic [17:0] lim_tlim;
   logic on_current;
   logic on_torque;
   logic on_freq;
   logic on_tlim;

   function automatic logic [17:0] scale_limit(input logic [15:0] base, input logic [8:0] pct);
      logic [24:0] prod;
      prod = 25'(base) * 25'(pct);
      scale_limit = 18'(prod / ROF_PCT_FULL);
   endfunction

   assign scale_neg = st_r.relay_one_limit_scaling[15];
   assign scale_abs = scale_neg ? 16'(-st_r.relay_one_limit_scaling) : st_r.relay_one_limit_scaling;

   always_comb
   begin
      if (scale_abs < 16'(ROF_SCALE_MIN_PCT))
      begin
         scale_pct = ROF_SCALE_MIN_PCT;
      end
      else if (scale_abs > 16'(ROF_SCALE_MAX_PCT))
      begin
         scale_pct = ROF_SCALE_MAX_PCT;
      end
      else
      begin
         scale_pct = scale_abs[8:0];
      end
   end

   assign lim_current = scale_limit(st_r.motor_rated_current, scale_pct);
   // torque limit from nominal torque current
   assign lim_torque = scale_limit(st_r.torque_nominal_current, scale_pct);
   assign lim_freq = scale_limit(st_r.motor_nominal_frequency, scale_pct);
   // threshold straight from the limit setting
   assign lim_tlim = 18'(st_r.torque_current_limit_setting);

   // one hysteresis comparator per limit, torque current feeds two
   rof_limit_cmp #(.VW(18)) u_cmp_current (
      .ref_clk(ref_clk),
      .rst(rst),
      .value(18'(output_current)),
      .limit(lim_current),
      .active(on_current)
   );

   rof_limit_cmp #(.VW(18)) u_cmp_torque (
      .ref_clk(ref_clk),
      .rst(rst),
      .value(18'(torque_current)),
      .limit(lim_torque),
      .active(on_torque)
   );

   rof_limit_cmp #(.VW(18)) u_cmp_freq (
      .ref_clk(ref_clk),
      .rst(rst),
      .value(18'(output_frequency)),
      .limit(lim_freq),
      .active(on_freq)
   );

   rof_limit_cmp #(.VW(18)) u_cmp_tlim (
      .ref_clk(ref_clk),
      .rst(rst),
      .value(18'(torque_current)),
      .limit(lim_tlim),
      .active(on_tlim)
   );

   ////////////////////////////////////////////////////////////////////////////
   // contact selection

   logic contact_sel;
   logic [5:0] sel;

   assign sel = st_r.relay_one_function_select;

   always_comb
   begin
      contact_sel = 1'b0;
      case (sel)
         ROF_FN_NONE: contact_sel = 1'b0;
         ROF_FN_BRAKE: contact_sel = brake_release;
         ROF_FN_RUNNING: contact_sel = inverter_running;
         ROF_FN_CURRENT: contact_sel = on_current ^ scale_neg;
         ROF_FN_TORQUE: contact_sel = on_torque ^ scale_neg;
         ROF_FN_FREQ: contact_sel = on_freq ^ scale_neg;
         // inverted sense, sign flips it back
         ROF_FN_TLIM_WARN: contact_sel = scale_neg ? on_tlim : !on_tlim;
         ROF_FN_FORCE: contact_sel = st_r.relay_force_setting;
         ROF_FN_TLIM_GEN: contact_sel = on_tlim & generator_range & vector_current_control;
         ROF_FN_BUS_OUT: contact_sel = bus_out_bit;
         default:
         begin
            if (sel >= ROF_FN_BUS_BIT0 && sel <= ROF_FN_BUS_BIT7)
            begin
               contact_sel = bus_in_bits[3'(sel - ROF_FN_BUS_BIT0)];
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb register file and state

   logic access;
   logic addr_ok;
   logic [31:0] rd_mux;

   // answer one cycle into the access phase
   assign access = psel && penable && !st_r.ready;

   always_comb
   begin
      addr_ok = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         ROF_OFS_FUNC_SEL: rd_mux = 32'(st_r.relay_one_function_select);
         ROF_OFS_SCALING: rd_mux = 32'(st_r.relay_one_limit_scaling);
         ROF_OFS_FORCE: rd_mux = 32'(st_r.relay_force_setting);
         ROF_OFS_MOTOR_CURRENT: rd_mux = 32'(st_r.motor_rated_current);
         ROF_OFS_MOTOR_FREQ: rd_mux = 32'(st_r.motor_nominal_frequency);
         ROF_OFS_TORQUE_NOM: rd_mux = 32'(st_r.torque_nominal_current);
         ROF_OFS_TORQUE_LIMIT: rd_mux = 32'(st_r.torque_current_limit_setting);
         ROF_OFS_STATUS: rd_mux = {27'h0000000, on_tlim, on_freq, on_torque, on_current, st_r.contact};
         default: addr_ok = 1'b0;
      endcase
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.contact = contact_sel;
      st_nxt.ready = access;
      st_nxt.slverr = access && !addr_ok;
      st_nxt.rdata = (access && !pwrite) ? rd_mux : 32'h00000000;
      if (access && pwrite)
      begin
         case (paddr)
            ROF_OFS_FUNC_SEL: st_nxt.relay_one_function_select = pwdata[5:0];
            ROF_OFS_SCALING: st_nxt.relay_one_limit_scaling = pwdata[15:0];
            ROF_OFS_FORCE: st_nxt.relay_force_setting = pwdata[0];
            ROF_OFS_MOTOR_CURRENT: st_nxt.motor_rated_current = pwdata[15:0];
            ROF_OFS_MOTOR_FREQ: st_nxt.motor_nominal_frequency = pwdata[15:0];
            ROF_OFS_TORQUE_NOM: st_nxt.torque_nominal_current = pwdata[15:0];
            ROF_OFS_TORQUE_LIMIT: st_nxt.torque_current_limit_setting = pwdata[15:0];
            default: st_nxt.relay_force_setting = st_r.relay_force_setting;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_r <= '0;
         st_r.relay_one_function_select <= ROF_RST_FUNC_SEL;
         st_r.relay_one_limit_scaling <= ROF_RST_SCALING;
         st_r.motor_rated_current <= ROF_RST_MOTOR_CURRENT;
         st_r.motor_nominal_frequency <= ROF_RST_MOTOR_FREQ;
         st_r.torque_nominal_current <= ROF_RST_TORQUE_NOM;
         st_r.torque_current_limit_setting <= ROF_RST_TORQUE_LIMIT;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.slverr;
   assign relay_contact = st_r.contact;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_sel_none;
      sel == ROF_FN_NONE |=> !relay_contact;
   endproperty
   a_sel_none: assert property (p_sel_none) else $error("contact closed with no function");

   property p_undefined;
      (sel > ROF_FN_BUS_OUT || (sel > ROF_FN_FREQ && sel < ROF_FN_TLIM_WARN)
         || (sel > ROF_FN_TLIM_GEN && sel < ROF_FN_BUS_BIT0)) |=> !relay_contact;
   endproperty
   a_undefined: assert property (p_undefined) else $error("contact closed on undefined setting");

   property p_brake;
      sel == ROF_FN_BRAKE |=> relay_contact == $past(brake_release);
   endproperty
   a_brake: assert property (p_brake) else $error("brake contact does not follow release");

   property p_running;
      sel == ROF_FN_RUNNING |=> relay_contact == $past(inverter_running);
   endproperty
   a_running: assert property (p_running) else $error("running contact wrong");

   property p_force;
      sel == ROF_FN_FORCE && $stable(st_r.relay_force_setting) |=> relay_contact == $past(st_r.relay_force_setting);
   endproperty
   a_force: assert property (p_force) else $error("forced contact does not follow bit 0");

   property p_bus7;
      sel == ROF_FN_BUS_BIT7 |=> relay_contact == $past(bus_in_bits[7]);
   endproperty
   a_bus7: assert property (p_bus7) else $error("bus bit 7 not on contact");

   property p_warn_inv;
      sel == ROF_FN_TLIM_WARN && !scale_neg |=> relay_contact == !$past(on_tlim);
   endproperty
   a_warn_inv: assert property (p_warn_inv) else $error("setting 11 sense not inverted");

   property p_gen;
      sel == ROF_FN_TLIM_GEN && !generator_range |=> !relay_contact;
   endproperty
   a_gen: assert property (p_gen) else $error("setting 13 closed outside generator range");

   property p_clamp;
      scale_abs < 16'(ROF_SCALE_MIN_PCT) |-> scale_pct == ROF_SCALE_MIN_PCT
         && lim_current == 18'(st_r.motor_rated_current / 16'(ROF_PCT_FULL / 25'(ROF_SCALE_MIN_PCT)));
   endproperty
   a_clamp: assert property (p_clamp) else $error("small scaling not clamped");

   property p_current;
      sel == ROF_FN_CURRENT && !scale_neg && 18'(output_current) >= lim_current
         ##1 sel == ROF_FN_CURRENT && !scale_neg |=> relay_contact;
   endproperty
   a_current: assert property (p_current) else $error("current limit did not close contact");

   property p_apb_ready;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("apb answer not one cycle");
endmodule

// [bench/rof_relay_load.sv]
// relay load partner: coil that picks up after the contact has stood closed
module rof_relay_load
#(
   parameter int PICKUP = 2
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // contact
   input wire logic relay_contact,
   // coil
   output logic load_on
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_r;
   // a short closure does not pick up the coil, as with a real load
   always_ff @(posedge ref_clk)
   begin
      if (rst || relay_contact !== 1'b1)
      begin
         cnt_r <= 8'h00;
         load_on <= 1'b0;
      end
      else if (cnt_r < PICKUP)
         cnt_r <= cnt_r + 8'h01;
      else
         load_on <= 1'b1;
   end
endmodule

// [bench/relay_output_function_selector_bench.sv]
// self-checking bench for the relay output function selector
module relay_output_function_selector_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import rof_pkg::*;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic brake_release, inverter_running, generator_range, vector_current_control;
   logic bus_out_bit, relay_contact, load_on;
   logic [7:0] paddr, bus_in_bits;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [15:0] output_current, torque_current, output_frequency;
   int miscompares, checks;
   int m_sel, m_scal, m_force, m_frq;
   bit c_cur, c_tor, c_frq, c_tl;
   localparam logic [7:0] R_OFS [7] = '{ROF_OFS_FUNC_SEL, ROF_OFS_SCALING, ROF_OFS_FORCE,
      ROF_OFS_MOTOR_CURRENT, ROF_OFS_MOTOR_FREQ, ROF_OFS_TORQUE_NOM, ROF_OFS_TORQUE_LIMIT};
   localparam logic [31:0] R_EXP [7] = '{{26'h0, ROF_RST_FUNC_SEL}, {16'h0, ROF_RST_SCALING}, 32'h0,
      {16'h0, ROF_RST_MOTOR_CURRENT}, {16'h0, ROF_RST_MOTOR_FREQ}, {16'h0, ROF_RST_TORQUE_NOM},
      {16'h0, ROF_RST_TORQUE_LIMIT}};
   localparam int SCALS [8] = '{0, 10, -10, -20, 20, -150, 400, 100};
   localparam int RAMP [6] = '{999, 1000, 901, 900, 899, 950};

   rof_relay_select i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .brake_release, .inverter_running, .generator_range, .vector_current_control,
      .output_current, .torque_current, .output_frequency, .bus_in_bits, .bus_out_bit, .relay_contact);
   rof_relay_load #(.PICKUP(2)) i_load (.ref_clk, .rst, .relay_contact, .load_on);

   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(logic [31:0] s);
      for (int i = 0; i < 16; i++)
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction
   function automatic bit hyst(bit act, int v, int lim);
      if (v >= lim)
         return 1'b1;
      if (v < lim - lim * 10 / 100)
         return 1'b0;
      return act;
   endfunction
   function automatic int lim_of(int base);
      int a;
      a = (m_scal < 0) ? -m_scal : m_scal;
      return base * ((a < 20) ? 20 : a) / 100;
   endfunction
   task automatic model_update();
      c_cur = hyst(c_cur, output_current, lim_of(ROF_RST_MOTOR_CURRENT));
      c_tor = hyst(c_tor, torque_current, lim_of(ROF_RST_TORQUE_NOM));
      c_frq = hyst(c_frq, output_frequency, lim_of(m_frq));
      c_tl = hyst(c_tl, torque_current, ROF_RST_TORQUE_LIMIT);
   endtask
   function automatic bit exp_contact();
      bit neg;
      neg = m_scal < 0;
      case (m_sel)
         1: return brake_release;
         2: return inverter_running;
         3: return c_cur ^ neg;
         4: return c_tor ^ neg;
         5: return c_frq ^ neg;
         11: return !c_tl ^ neg;
         12: return m_force[0];
         13: return c_tl && generator_range && vector_current_control;
         38: return bus_out_bit;
         default: return (m_sel >= 30 && m_sel <= 37) ? bus_in_bits[m_sel-30] : 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////
   task automatic chk_word(logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(logic got, logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(bit wr, logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      // only the watchdog ends a wait that never answers
      while (pready !== 1'b1)
      begin
         @(posedge ref_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic step(int cur);
      seed = lfsr(seed);
      output_current <= (cur < 0) ? 16'(seed[15:0] % 16'd1300) : 16'(cur);
      torque_current <= 16'(seed[31:16] % 16'd1300);
      seed = lfsr(seed);
      output_frequency <= 16'(seed[15:0] % 16'd800);
      {brake_release, inverter_running, generator_range, vector_current_control, bus_out_bit} <= seed[20:16];
      bus_in_bits <= seed[28:21];
      repeat (6) @(posedge ref_clk);
      model_update();
      chk_bit(relay_contact, exp_contact());
      chk_bit(load_on, exp_contact());
      apb(1'b0, ROF_OFS_STATUS, 32'h0);
      chk_word(rd, {27'h0, c_tl, c_frq, c_tor, c_cur, exp_contact()});
   endtask
   task automatic final_report();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // well above the roughly 17k cycles the sequence needs
   initial
   begin
      #1600000;
      miscompares++;
      final_report();
   end
   initial
   begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {brake_release, inverter_running, generator_range, vector_current_control, bus_out_bit} = 5'h00;
      {output_current, torque_current, output_frequency, bus_in_bits} = 56'h0;
      {seed, m_sel, m_scal, m_force, m_frq} = {32'd88598, 32'd1, 32'd100, 32'd0, 32'd500};
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, R_OFS[i], 32'h0);
         chk_word(rd, R_EXP[i]);
         chk_bit(err, 1'b0);
      end
      apb(1'b1, 8'h40, 32'hffffffff);
      chk_bit(err, 1'b1);
      apb(1'b0, 8'h40, 32'h0);
      chk_word({rd[31:1], err}, 32'h1);
      apb(1'b1, ROF_OFS_STATUS, 32'hffffffff);
      apb(1'b1, ROF_OFS_MOTOR_FREQ, 32'h0000012c);
      m_frq = 300;
      apb(1'b1, ROF_OFS_FUNC_SEL, 32'h3);
      m_sel = 3;
      foreach (RAMP[i])
         step(RAMP[i]);
      foreach (SCALS[k])
      begin
         apb(1'b1, ROF_OFS_SCALING, 32'(SCALS[k]));
         m_scal = SCALS[k];
         repeat (3) @(posedge ref_clk);
         model_update();
         for (int s = 0; s < 64; s++)
         begin
            seed = lfsr(seed);
            apb(1'b1, ROF_OFS_FUNC_SEL, {seed[31:6], 6'(s)});
            m_sel = s;
            apb(1'b0, ROF_OFS_FUNC_SEL, 32'h0);
            chk_word(rd, 32'(s));
            apb(1'b1, ROF_OFS_FORCE, seed);
            m_force = int'(seed[0]);
            step(-1);
            step(-1);
         end
      end
      final_report();
   end
endmodule
